// [rtl/bst_tap.v]
// Purpose: boundary-scan test access port controller
// Assumes: test pins are asynchronous to MCLK and far slower than it
// Notes: test clock edges are found by sampling on MCLK
// Function
// - State advances only on test clock rising edges, using mode-select.
// - Test reset release leaves reset state with identify instruction.
// - Five clocks with mode-select high reach the reset state.
// - In reset state no test override reaches system logic.
// - Idle and select states hold all scan registers.
// - Select-DR goes to Capture-DR on low, Select-IR on high.
// - Capture-DR loads selected register; then Shift-DR or Exit1-DR.
// - Shift-DR shifts selected register toward output; others hold.
// - Exit1-DR goes to Update-DR on high, Pause-DR on low.
// - Pause-DR holds; leaves to Exit2-DR on high.
// - Exit2-DR goes to Update-DR on high, Shift-DR on low.
// - Update-DR falling edge copies shift path to output latches.
// - Update states go to Idle on low, Select-DR on high.
// - Select-IR goes to Capture-IR on low, reset on high.
// - Capture-IR loads 001; then Exit1-IR on high, Shift-IR on low.
// - Shift-IR shifts instruction register; high moves to Exit1-IR.
// - Exit1-IR goes to Pause-IR on low, Update-IR on high.
// - Pause-IR halts shifting; leaves to Exit2-IR on high.
// - Exit2-IR goes to Update-IR on high, Shift-IR on low.
// - Update-IR falling edge latches instruction as current one.
// - Decode all six instructions; provide bypass, boundary, identify.
// - Port has clock, data in, data out, mode-select, reset.
// - Instruction register is 3-bit shift with latched output.
// - Codes decode as listed; 101 and 110 select bypass.
// - Bypass routes data in to out through one bit.
`timescale 1ns/1ps
`include "bst_defines.vh"
module bst_tap #(
  parameter BSR_W = 8,
  parameter [`BST_ID_W-1:0] ID_CODE = 32'h0000_0001
) (
  // Clock and reset
  input wire MCLK,
  input wire RST,
  // Test port pins
  input wire TEST_CLOCK_PIN,
  input wire TEST_MODE_SELECT_PIN,
  input wire TEST_DATA_IN_PIN,
  input wire TEST_RESET_N_PIN,
  output reg TEST_DATA_OUT_PIN,
  output reg TEST_DATA_OUT_OE,
  // Boundary cells toward the pads
  input wire [BSR_W-1:0] PAD_IN,
  input wire [BSR_W-1:0] SYS_OUT,
  output wire [BSR_W-1:0] PAD_OUT,
  output wire PAD_HIGHZ,
  // Latched current instruction code
  output wire [`BST_IR_W-1:0] INSTR
);
  // ********************
  // Pin synchronisers
  // ********************
  // Pins are asynchronous; two flops per pin before any logic
  wire tck;
  wire tms;
  wire tdi;
  wire trst_n;
  reg tck_d_r;
  bst_sync2 #(.RST_VAL(`BST_RST_TCK)) u_sync_tck (
    .clk(MCLK),
    .rst(RST),
    .din(TEST_CLOCK_PIN),
    .dout(tck)
  );
  bst_sync2 #(.RST_VAL(`BST_RST_TMS)) u_sync_tms (
    .clk(MCLK),
    .rst(RST),
    .din(TEST_MODE_SELECT_PIN),
    .dout(tms)
  );
  bst_sync2 #(.RST_VAL(`BST_RST_TDI)) u_sync_tdi (
    .clk(MCLK),
    .rst(RST),
    .din(TEST_DATA_IN_PIN),
    .dout(tdi)
  );
  bst_sync2 #(.RST_VAL(`BST_RST_TRSTN)) u_sync_trst (
    .clk(MCLK),
    .rst(RST),
    .din(TEST_RESET_N_PIN),
    .dout(trst_n)
  );
  // Reset level equals idle clock level, so no false edge after reset
  always @(posedge MCLK) begin
    if (RST) begin
      tck_d_r <= `BST_RST_TCK;
    end else begin
      tck_d_r <= tck;
    end
  end
  // Edges are late by three system clocks; phases must outlast that
  // edge detection
  wire rise = tck & ~tck_d_r;
  wire fall = ~tck & tck_d_r;

  // ********************
  // Controller state
  // ********************
  reg [`BST_ST_N-1:0] st_r;
  reg [`BST_ST_N-1:0] st_nxt;
  always @* begin
    st_nxt = {`BST_ST_N{1'b0}};
    case (1'b1)
      st_r[`BST_ST_TLR]: st_nxt[tms ? `BST_ST_TLR : `BST_ST_RTI] = 1'b1;
      st_r[`BST_ST_RTI]: st_nxt[tms ? `BST_ST_SDR : `BST_ST_RTI] = 1'b1;
      st_r[`BST_ST_SDR]: st_nxt[tms ? `BST_ST_SIR : `BST_ST_CDR] = 1'b1;
      st_r[`BST_ST_CDR]: st_nxt[tms ? `BST_ST_E1DR : `BST_ST_SHDR] = 1'b1;
      st_r[`BST_ST_SHDR]: st_nxt[tms ? `BST_ST_E1DR : `BST_ST_SHDR] = 1'b1;
      st_r[`BST_ST_E1DR]: st_nxt[tms ? `BST_ST_UDR : `BST_ST_PDR] = 1'b1;
      st_r[`BST_ST_PDR]: st_nxt[tms ? `BST_ST_E2DR : `BST_ST_PDR] = 1'b1;
      st_r[`BST_ST_E2DR]: st_nxt[tms ? `BST_ST_UDR : `BST_ST_SHDR] = 1'b1;
      st_r[`BST_ST_UDR]: st_nxt[tms ? `BST_ST_SDR : `BST_ST_RTI] = 1'b1;
      st_r[`BST_ST_UIR]: st_nxt[tms ? `BST_ST_SDR : `BST_ST_RTI] = 1'b1;
      st_r[`BST_ST_SIR]: st_nxt[tms ? `BST_ST_TLR : `BST_ST_CIR] = 1'b1;
      st_r[`BST_ST_CIR]: st_nxt[tms ? `BST_ST_E1IR : `BST_ST_SHIR] = 1'b1;
      st_r[`BST_ST_SHIR]: st_nxt[tms ? `BST_ST_E1IR : `BST_ST_SHIR] = 1'b1;
      st_r[`BST_ST_E1IR]: st_nxt[tms ? `BST_ST_UIR : `BST_ST_PIR] = 1'b1;
      st_r[`BST_ST_PIR]: st_nxt[tms ? `BST_ST_E2IR : `BST_ST_PIR] = 1'b1;
      st_r[`BST_ST_E2IR]: st_nxt[tms ? `BST_ST_UIR : `BST_ST_SHIR] = 1'b1;
      default: st_nxt[`BST_ST_TLR] = 1'b1;
    endcase
  end
  // five high edges end in reset via the table above
  always @(posedge MCLK) begin
    if (RST) begin
      st_r <= {{(`BST_ST_N-1){1'b0}}, 1'b1};
    end else if (!trst_n) begin
      // held in reset while the pin is low
      st_r <= {{(`BST_ST_N-1){1'b0}}, 1'b1};
    end else if (rise) begin
      st_r <= st_nxt;
    end
  end

  // ********************
  // Instruction register
  // ********************
  reg [`BST_IR_W-1:0] ir_sh_r;
  reg [`BST_IR_W-1:0] ir_r;
  always @(posedge MCLK) begin
    if (RST) begin
      ir_sh_r <= `BST_IR_CAPTURE;
      ir_r <= `BST_OP_IDCODE;
    end else if (!trst_n || st_r[`BST_ST_TLR]) begin
      ir_r <= `BST_OP_IDCODE;
    end else if (rise && st_r[`BST_ST_CIR]) begin
      ir_sh_r <= `BST_IR_CAPTURE;
    end else if (rise && st_r[`BST_ST_SHIR]) begin
      ir_sh_r <= {tdi, ir_sh_r[`BST_IR_W-1:1]};
    end else if (fall && st_r[`BST_ST_UIR]) begin
      ir_r <= ir_sh_r;
    end
  end
  assign INSTR = ir_r;

  // ********************
  // Instruction decode
  // ********************
  // code table
  wire sel_bsr = (ir_r == `BST_OP_EXTEST) || (ir_r == `BST_OP_SAMPLE);
  wire sel_id = (ir_r == `BST_OP_IDCODE);
  wire sel_byp = ~sel_bsr & ~sel_id;

  // ********************
  // Data registers
  // ********************
  reg byp_r;
  reg [`BST_ID_W-1:0] id_r;
  reg [BSR_W-1:0] bsr_r;
  reg [BSR_W-1:0] bsr_upd_r;
  wire cap = rise & st_r[`BST_ST_CDR];
  wire shf = rise & st_r[`BST_ST_SHDR];
  // Exit edge out of Shift-DR still shifts, as the graph demands
  // only capture or shift edges change them
  always @(posedge MCLK) begin
    if (RST) begin
      byp_r <= 1'b0;
      id_r <= {`BST_ID_W{1'b0}};
      bsr_r <= {BSR_W{1'b0}};
    end else begin
      if (cap && sel_byp)
        byp_r <= 1'b0;
      else if (shf && sel_byp)
        byp_r <= tdi;
      if (cap && sel_id)
        id_r <= ID_CODE;
      else if (shf && sel_id)
        id_r <= {tdi, id_r[`BST_ID_W-1:1]};
      if (cap && sel_bsr)
        bsr_r <= PAD_IN;
      else if (shf && sel_bsr)
        bsr_r <= {tdi, bsr_r[BSR_W-1:1]};
    end
  end
  always @(posedge MCLK) begin
    if (RST)
      bsr_upd_r <= {BSR_W{1'b0}};
    else if (fall && st_r[`BST_ST_UDR] && sel_bsr)
      bsr_upd_r <= bsr_r;
  end

  // ********************
  // Pad override
  // ********************
  // Instruction only lives past reset, so reset state means no override
  // normal pads in reset
  wire ovr = ~st_r[`BST_ST_TLR] &
    ((ir_r == `BST_OP_EXTEST) || (ir_r == `BST_OP_CLAMP));
  assign PAD_OUT = ovr ? bsr_upd_r : SYS_OUT;
  assign PAD_HIGHZ = ~st_r[`BST_ST_TLR] & (ir_r == `BST_OP_HIGHZ);

  // ********************
  // Serial output
  // ********************
  reg so;
  always @* begin
    if (st_r[`BST_ST_SHIR])
      so = ir_sh_r[0];
    else if (sel_id)
      so = id_r[0];
    else if (sel_bsr)
      so = bsr_r[0];
    else
      so = byp_r;
  end
  // falling-edge output, driven only while shifting
  always @(posedge MCLK) begin
    if (RST) begin
      TEST_DATA_OUT_PIN <= 1'b0;
      TEST_DATA_OUT_OE <= 1'b0;
    end else if (fall) begin
      TEST_DATA_OUT_PIN <= so;
      TEST_DATA_OUT_OE <= st_r[`BST_ST_SHDR] | st_r[`BST_ST_SHIR];
    end
  end
endmodule // bst_tap

// ********************
// Two-flop synchroniser
// ********************
module bst_sync2 #(
  parameter [0:0] RST_VAL = 1'b0
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Pin level and its synced copy
  input wire din,
  output reg dout
);
  // First stage may be metastable; only dout is read outside
  reg meta_r;
  always @(posedge clk) begin
    if (rst) begin
      meta_r <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule // bst_sync2

// [common/bst_defines.vh]
// Purpose: constants for the boundary-scan test port controller
// Assumes: 3-bit instruction register
// Notes: state codes are one-hot, index positions below
`ifndef BST_DEFINES_VH
`define BST_DEFINES_VH
`define BST_IR_W 3
`define BST_IR_CAPTURE 3'h1
`define BST_OP_EXTEST 3'h0
`define BST_OP_IDCODE 3'h1
`define BST_OP_SAMPLE 3'h2
`define BST_OP_CLAMP 3'h3
`define BST_OP_HIGHZ 3'h4
`define BST_OP_BYPASS 3'h7
`define BST_ID_W 32
`define BST_ST_TLR 0
`define BST_ST_RTI 1
`define BST_ST_SDR 2
`define BST_ST_CDR 3
`define BST_ST_SHDR 4
`define BST_ST_E1DR 5
`define BST_ST_PDR 6
`define BST_ST_E2DR 7
`define BST_ST_UDR 8
`define BST_ST_SIR 9
`define BST_ST_CIR 10
`define BST_ST_SHIR 11
`define BST_ST_E1IR 12
`define BST_ST_PIR 13
`define BST_ST_E2IR 14
`define BST_ST_UIR 15
`define BST_ST_N 16
`define BST_RST_TCK 1'b0
`define BST_RST_TMS 1'b1
`define BST_RST_TDI 1'b0
`define BST_RST_TRSTN 1'b1
`endif

// [testbench/bst_tap_monitor.sv]
// Purpose: port checker for bst_tap
// Assumes: test clock far slower than MCLK
// Notes: bound below the module
`timescale 1ns/1ps
`include "bst_defines.vh"
module bst_tap_monitor #(parameter BSR_W = 8) (
  // Watched ports
  input wire MCLK,
  input wire RST,
  input wire TEST_CLOCK_PIN,
  input wire TEST_RESET_N_PIN,
  input wire TEST_DATA_OUT_PIN,
  input wire TEST_DATA_OUT_OE,
  input wire [BSR_W-1:0] SYS_OUT,
  input wire [BSR_W-1:0] PAD_OUT,
  input wire PAD_HIGHZ,
  input wire [`BST_IR_W-1:0] INSTR
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);
  AST_RST_CLEAR: assert property ($fell(RST) |->
    !TEST_DATA_OUT_OE && !PAD_HIGHZ && INSTR == `BST_OP_IDCODE)
    else $error("reset state wrong");
  AST_TRST_ID: assert property ((!TEST_RESET_N_PIN)[*6] |->
    INSTR == `BST_OP_IDCODE) else $error("test reset ignored");
  AST_PAD_NORMAL: assert property ((INSTR != `BST_OP_EXTEST &&
    INSTR != `BST_OP_CLAMP) |-> PAD_OUT == SYS_OUT)
    else $error("pads overridden");
  AST_HIGHZ: assert property (PAD_HIGHZ |->
    INSTR == `BST_OP_HIGHZ) else $error("stray high-z");
  AST_INSTR_FALL: assert property (($changed(INSTR) &&
    INSTR != `BST_OP_IDCODE) |-> !TEST_CLOCK_PIN)
    else $error("instruction off falling edge");
  AST_TDO_FALL: assert property ($changed(TEST_DATA_OUT_PIN) |->
    !TEST_CLOCK_PIN) else $error("data out off falling edge");
  AST_OE_FALL: assert property ($changed(TEST_DATA_OUT_OE) |->
    !TEST_CLOCK_PIN) else $error("enable off falling edge");
  AST_CLOCK_STILL: assert property ((TEST_RESET_N_PIN &&
    $stable(TEST_CLOCK_PIN))[*8] |-> $stable(INSTR) &&
    $stable(TEST_DATA_OUT_OE)) else $error("moved without clock");
  cover property ($rose(TEST_DATA_OUT_OE));
  cover property (PAD_HIGHZ);
  cover property (INSTR == `BST_OP_EXTEST && PAD_OUT != SYS_OUT);
endmodule // bst_tap_monitor
bind bst_tap bst_tap_monitor #(.BSR_W(BSR_W)) u_mon (.MCLK(MCLK),
  .RST(RST), .TEST_CLOCK_PIN(TEST_CLOCK_PIN),
  .TEST_RESET_N_PIN(TEST_RESET_N_PIN),
  .TEST_DATA_OUT_PIN(TEST_DATA_OUT_PIN),
  .TEST_DATA_OUT_OE(TEST_DATA_OUT_OE), .SYS_OUT(SYS_OUT),
  .PAD_OUT(PAD_OUT), .PAD_HIGHZ(PAD_HIGHZ), .INSTR(INSTR));

// [testbench/bst_tester.sv]
// Purpose: tester model on the far side of the test port
// Assumes: 160 ns test clock, still between frames
// Notes: released data out reads as pulled high
`timescale 1ns/1ps
module bst_tester (
  // Test port
  input wire mclk,
  output reg tck = 1'b0,
  output reg tms = 1'b1,
  output reg tdi = 1'b0,
  input wire tdo,
  input wire oe
);
  // ****
  // Clocking
  // ****
  // tester drives pins, n clocks
  task seq(input integer n, input logic [31:0] m,
    input logic [31:0] v, output logic [31:0] q);
    q = 32'h0;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      tms <= m[i];
      tdi <= v[i];
      repeat (9) @(posedge mclk);
      tck <= 1'b1;
      q[i] = oe ? tdo : 1'b1;
      repeat (10) @(posedge mclk);
      tck <= 1'b0;
    end
  endtask
endmodule // bst_tester

// [testbench/bst_tap_tb.sv]
// Purpose: self-checking bench for bst_tap
// Assumes: tester model drives the test pins
// Notes: scenarios run back to back from one reset
`timescale 1ns/1ps
module bst_tap_tb;
  // Arbitrary identity value
  localparam [31:0] ID = 32'h5a3c_9e21;
  reg MCLK = 1'b0;
  reg RST = 1'b1;
  reg trst_n = 1'b1;
  reg [7:0] pad_in = 8'h3c;
  reg [7:0] sys_out = 8'h5a;
  wire tck, tms, tdi, tdo, oe, pad_z;
  wire [7:0] pad_out;
  wire [2:0] instr;
  logic [31:0] d, j;
  integer num_errors = 0;
  integer comparisons = 0;
  integer cycles = 0;
  always #4 MCLK = ~MCLK;
  bst_tap #(.ID_CODE(ID)) u_dut (.MCLK(MCLK), .RST(RST),
    .TEST_CLOCK_PIN(tck), .TEST_MODE_SELECT_PIN(tms),
    .TEST_DATA_IN_PIN(tdi), .TEST_RESET_N_PIN(trst_n),
    .TEST_DATA_OUT_PIN(tdo), .TEST_DATA_OUT_OE(oe), .PAD_IN(pad_in),
    .SYS_OUT(sys_out), .PAD_OUT(pad_out), .PAD_HIGHZ(pad_z),
    .INSTR(instr));
  bst_tester u_tst (.mclk(MCLK), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .oe(oe));
  // ****
  // Helpers and scenarios
  // ****
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask
  task ir(input logic [2:0] c);
    u_tst.seq(4, 32'h3, 32'h0, j);
    u_tst.seq(3, 32'h4, {29'h0, c}, d);
    chk(d, 32'h1);
    u_tst.seq(5, 32'hc, 32'h0, j);
    chk(instr, c);
  endtask
  task dr(input integer n, input logic [31:0] v);
    u_tst.seq(3, 32'h1, 32'h0, j);
    u_tst.seq(n, 32'h1 << (n - 1), v, d);
    u_tst.seq(2, 32'h1, 32'h0, j);
  endtask
  task t_idcode;
    u_tst.seq(1, 32'h0, 32'h0, j);
    dr(32, 32'h0);
    chk(d, ID);
  endtask
  task t_codes;
    for (int c = 0; c < 8; c++) begin
      ir(c[2:0]);
      chk(pad_z, c == 4);
      if (c != 0 && c != 3) chk(pad_out, sys_out);
    end
  endtask
  task t_bypass;
    ir(3'h7);
    dr(8, 32'hb6);
    chk(d, 32'h6c);
  endtask
  task t_extest;
    ir(3'h2);
    dr(8, 32'ha5);
    chk(d, pad_in);
    ir(3'h0);
    chk(pad_out, 8'ha5);
  endtask
  task t_reset;
    ir(3'h7);
    u_tst.seq(9, 32'h0f9, 32'h0, j);
    chk(instr, 3'h1);
    ir(3'h4);
    @(posedge MCLK) trst_n <= 1'b0;
    repeat (8) @(posedge MCLK);
    chk(instr, 3'h1);
    chk(pad_z, 1'b0);
    @(posedge MCLK) trst_n <= 1'b1;
    repeat (4) @(posedge MCLK);
    t_idcode;
  endtask
  task stop_test;
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    repeat (4) @(posedge MCLK);
    t_idcode;
    t_codes;
    t_bypass;
    t_extest;
    t_reset;
    stop_test;
  end
  // Hang guard, far above the expected run
  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      stop_test;
    end
  end
endmodule // bst_tap_tb
